// ### src/runtime_misc_register_bank.sv
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps

// Operation
// - The force-change bit resets to 1 and software can set it but never clear it.
// - The force-change bit clears when a head step and drive select 0 occur together.
// - Disk change status is (drive_select0_n high AND force-change) OR disk change input.
// - While force-change is 1 and drive_select0_n is high the disk change input is taken as active.
// - The floppy shadow shows rate, precompensation, power down and soft reset.
// - The first serial shadow holds the last FIFO control write of that port.
// - The second serial shadow holds that port's FIFO control write, same layout.
// - A zero interrupt-generating bit drives its frame low in the serial IRQ stream.
// - The interrupt-generating registers act only while the enable bit is set.
// - The low generator maps bits 7:1 to IRQ7..1 and resets to all ones on both resets.
// - The high generator maps bits 7:0 to IRQ15..8 and resets to all ones on both resets.
// - Reads of the generators return the present bit state.
// - Writing 0 to a generator bit makes it 0 and writing 1 returns it to 1.
// - Only software writes and the two resets change the generator bits.
// - A generated frame overrides every other source for that frame.
// - The two reserved tail offsets are read-only and read as zero.
module runtime_misc_register_bank
    import runtime_misc_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  hard_reset_n,
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [DATA_W-1:0]     s_axi_wdata,
    input  wire logic [DATA_W/8-1:0]   s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [DATA_W-1:0]          s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  head_step_pulse_n,
    input  wire logic                  drive_select0_n,
    input  wire logic                  disk_change_in_n,
    output logic                       disk_change_status,
    input  wire logic [1:0]            data_rate_select,
    input  wire logic [2:0]            write_select_a,
    input  wire logic                  floppy_power_down,
    input  wire logic                  floppy_soft_reset,
    input  wire logic                  serial_a_fifo_ctl_wr,
    input  wire logic [7:0]            serial_a_fifo_ctl_data,
    input  wire logic                  serial_b_fifo_ctl_wr,
    input  wire logic [7:0]            serial_b_fifo_ctl_data,
    input  wire logic                  irq_generate_enable,
    input  wire logic [15:0]           other_irq_frame_level,
    output logic [15:0]                irq_frame_force_bit,
    output logic [15:0]                serirq_frame_level
);

    typedef struct packed {
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [DATA_W-1:0] rdata;
        logic              aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_held;
        logic [7:0]        w_byte;
        logic              w_lane0;
        logic              force_change;
        logic [7:0]        gen_low;
        logic [7:0]        gen_high;
        logic [7:0]        rate_shadow;
        logic [7:0]        ser_a_shadow;
        logic [7:0]        ser_b_shadow;
        logic              disk_change;
        logic [15:0]       force_frames;
        logic [15:0]       frame_level;
    } state_t;

    localparam state_t RESET_STATE = '{
        awready:      1'b0,
        wready:       1'b0,
        bvalid:       1'b0,
        bresp:        RESP_OKAY,
        arready:      1'b0,
        rvalid:       1'b0,
        rresp:        RESP_OKAY,
        rdata:        '0,
        aw_held:      1'b0,
        aw_addr:      '0,
        w_held:       1'b0,
        w_byte:       8'h00,
        w_lane0:      1'b0,
        force_change: FORCE_CHG_RST,
        gen_low:      GEN_RST,
        gen_high:     GEN_RST,
        rate_shadow:  SHADOW_RST,
        ser_a_shadow: SHADOW_RST,
        ser_b_shadow: SHADOW_RST,
        disk_change:  1'b0,
        force_frames: 16'h0000,
        frame_level:  16'h0000
    };

    state_t st;
    state_t next_st;

    // word index of a byte address; both address channels use it
    function automatic logic [IDX_W-1:0] reg_index(
        input logic [ADDR_W-1:0] addr
    );
        reg_index = addr[ADDR_W-1:2];
    endfunction : reg_index

    function automatic logic mapped(input logic [ADDR_W-1:0] addr);
        logic [IDX_W-1:0] idx;
        idx    = reg_index(addr);
        mapped = (idx >= IDX_FORCE_CHG) && (idx <= IDX_RSVD_1);
    endfunction : mapped

    // byte seen by software at a given index
    function automatic logic [7:0] read_byte(
        input logic [IDX_W-1:0] idx,
        input state_t           s
    );
        read_byte = 8'h00;
        unique case (idx)
            IDX_FORCE_CHG:   read_byte = {7'h00, s.force_change};
            IDX_RATE_SHADOW: read_byte = s.rate_shadow;
            IDX_SER_A_FCR:   read_byte = s.ser_a_shadow;
            IDX_GEN_LOW:     read_byte = s.gen_low;
            IDX_GEN_HIGH:    read_byte = s.gen_high;
            IDX_SER_B_FCR:   read_byte = s.ser_b_shadow;
            IDX_RSVD_0:      read_byte = 8'h00;
            IDX_RSVD_1:      read_byte = 8'h00;
            default:         read_byte = 8'h00;
        endcase
    endfunction : read_byte

    always_comb begin
        logic             do_write;
        logic [IDX_W-1:0] w_idx;
        logic             step_clear;
        logic [15:0]      gen_frames;
        do_write   = 1'b0;
        w_idx      = '0;
        step_clear = 1'b0;
        gen_frames = 16'h0000;
        next_st    = st;

        // write channels are taken independently, in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_held  = 1'b1;
            next_st.w_byte  = s_axi_wdata[7:0];
            next_st.w_lane0 = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // commit in the same cycle as the later of the two handshakes
        if (next_st.aw_held && next_st.w_held && !next_st.bvalid) begin
            do_write        = next_st.w_lane0 && mapped(next_st.aw_addr);
            w_idx           = reg_index(next_st.aw_addr);
            next_st.bvalid  = 1'b1;
            next_st.bresp   = mapped(next_st.aw_addr) ? RESP_OKAY
                                                      : RESP_SLVERR;
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
        end
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready  = !next_st.w_held && !next_st.bvalid;

        // read path: one outstanding read, data registered with rvalid
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = {24'h000000,
                              read_byte(reg_index(s_axi_araddr), st)};
            next_st.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        next_st.arready = !next_st.rvalid && !(s_axi_arvalid && st.arready);

        // head step together with drive 0 selected ends a forced change
        step_clear = !head_step_pulse_n && !drive_select0_n;
        if (step_clear) begin
            next_st.force_change = 1'b0;
        end
        // a software set lands after the clear so the set wins
        if (do_write && (w_idx == IDX_FORCE_CHG)
                && next_st.w_byte[FORCE_CHG_BIT]) begin
            next_st.force_change = 1'b1;
        end

        // generators change only through these writes, hard_reset_n and aresetn
        if (do_write && (w_idx == IDX_GEN_LOW)) begin
            next_st.gen_low = next_st.w_byte;
        end
        if (do_write && (w_idx == IDX_GEN_HIGH)) begin
            next_st.gen_high = next_st.w_byte;
        end
        if (!hard_reset_n) begin
            next_st.gen_low  = GEN_RST;
            next_st.gen_high = GEN_RST;
        end

        // shadows: floppy follows live settings, serial ports capture writes
        next_st.rate_shadow = RATE_LIVE_MASK & {
            floppy_soft_reset, floppy_power_down, 1'b0,
            write_select_a, data_rate_select};
        if (serial_a_fifo_ctl_wr) begin
            next_st.ser_a_shadow = serial_a_fifo_ctl_data
                                   & FCR_LIVE_MASK;
        end
        if (serial_b_fifo_ctl_wr) begin
            next_st.ser_b_shadow = serial_b_fifo_ctl_data
                                   & FCR_LIVE_MASK;
        end

        // forced bit holds the status high while drive_select0_n is high, like an active input would
        next_st.disk_change = (drive_select0_n && st.force_change)
                              || disk_change_in_n;

        // IRQ0 has no generator bit; a zero bit asks for its frame low
        gen_frames = ~{st.gen_high, st.gen_low[7:1], 1'b1};
        next_st.force_frames = irq_generate_enable ? gen_frames
                                                   : 16'h0000;
        next_st.frame_level  = other_irq_frame_level
                               & ~next_st.force_frames;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready       = st.awready;
    assign s_axi_wready        = st.wready;
    assign s_axi_bvalid        = st.bvalid;
    assign s_axi_bresp         = st.bresp;
    assign s_axi_arready       = st.arready;
    assign s_axi_rvalid        = st.rvalid;
    assign s_axi_rresp         = st.rresp;
    assign s_axi_rdata         = st.rdata;
    assign disk_change_status  = st.disk_change;
    assign irq_frame_force_bit = st.force_frames;
    assign serirq_frame_level  = st.frame_level;

endmodule : runtime_misc_register_bank

// ### src/runtime_misc_pkg.sv
package runtime_misc_pkg;

    // bus geometry
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          IDX_W           = 6;

    // register indices; byte address is four times the index
    localparam logic [5:0]  IDX_FORCE_CHG   = 6'h18;
    localparam logic [5:0]  IDX_RATE_SHADOW = 6'h19;
    localparam logic [5:0]  IDX_SER_A_FCR   = 6'h1A;
    localparam logic [5:0]  IDX_GEN_LOW     = 6'h1B;
    localparam logic [5:0]  IDX_GEN_HIGH    = 6'h1C;
    localparam logic [5:0]  IDX_SER_B_FCR   = 6'h1D;
    localparam logic [5:0]  IDX_RSVD_0      = 6'h1E;
    localparam logic [5:0]  IDX_RSVD_1      = 6'h1F;

    // field positions
    localparam int          FORCE_CHG_BIT   = 0;
    localparam int          RATE_LSB        = 0;
    localparam int          WRITE_SELECT_A_LSB     = 2;
    localparam int          PWR_DOWN_BIT    = 6;
    localparam int          SOFT_RST_BIT    = 7;
    localparam logic [7:0]  FCR_LIVE_MASK   = 8'hCF;
    localparam logic [7:0]  FORCE_CHG_MASK  = 8'h01;
    localparam logic [7:0]  RATE_LIVE_MASK  = 8'hDF;

    // reset values
    localparam logic        FORCE_CHG_RST   = 1'b1;
    localparam logic [7:0]  GEN_RST         = 8'hFF;
    localparam logic [7:0]  SHADOW_RST      = 8'h00;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage : runtime_misc_pkg

// ### verification/misc_bank_props.sv
`timescale 1ns/10ps
module misc_bank_props (
    input logic        aclk,
    input logic        aresetn,
    input logic [7:0]  s_axi_araddr,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic        drive_select0_n,
    input logic        disk_change_in_n,
    input logic        disk_change_status,
    input logic        irq_generate_enable,
    input logic [15:0] other_irq_frame_level,
    input logic [15:0] irq_frame_force_bit,
    input logic [15:0] serirq_frame_level
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    property p_dsk_in;
        $past(aresetn) && $past(disk_change_in_n) |-> disk_change_status;
    endproperty
    property p_dsk_low;
        $past(aresetn) && $past(!drive_select0_n && !disk_change_in_n)
            |-> !disk_change_status;
    endproperty
    property p_bit0;
        irq_frame_force_bit[0] == 1'b0;
    endproperty
    property p_en_off;
        $past(aresetn) && !$past(irq_generate_enable)
            |-> irq_frame_force_bit == 16'h0000;
    endproperty
    // a forced frame must win over whatever the other sources say
    property p_override;
        $past(aresetn) |-> serirq_frame_level ==
            ($past(other_irq_frame_level) & ~irq_frame_force_bit);
    endproperty
    property p_rsvd;
        s_rd_take ##0 s_axi_araddr[7:3] == 5'h0F |=> s_axi_rdata == 32'h0;
    endproperty
    property p_rd_ans;
        s_rd_take |=> s_axi_rvalid ##0 !s_axi_arready;
    endproperty
    property p_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_rd_hi;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_dsk_in: assert property (p_dsk_in)
        else $error("change status low while change input high");
    a_dsk_low: assert property (p_dsk_low)
        else $error("change status high with both inputs low");
    a_bit0: assert property (p_bit0)
        else $error("frame 0 forced");
    a_en_off: assert property (p_en_off)
        else $error("frame forced while generation disabled");
    a_override: assert property (p_override)
        else $error("forced frame not low in stream");
    a_rsvd: assert property (p_rsvd)
        else $error("reserved tail read nonzero");
    a_rd_ans: assert property (p_rd_ans)
        else $error("read answer missing");
    a_hold: assert property (p_hold)
        else $error("read data not held");
    a_rd_hi: assert property (p_rd_hi)
        else $error("upper read bits nonzero");
endmodule : misc_bank_props

bind runtime_misc_register_bank misc_bank_props u_props (.aclk, .aresetn,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .drive_select0_n, .disk_change_in_n,
    .disk_change_status, .irq_generate_enable, .other_irq_frame_level,
    .irq_frame_force_bit, .serirq_frame_level);

// ### verification/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import runtime_misc_pkg::*;
;
    logic aclk, aresetn, hard_reset_n, s_axi_awvalid, s_axi_awready;
    logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic head_step_pulse_n, drive_select0_n, disk_change_in_n;
    logic disk_change_status, floppy_power_down, floppy_soft_reset;
    logic serial_a_fifo_ctl_wr, serial_b_fifo_ctl_wr, irq_generate_enable;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, ga, gb, gl, gh;
    logic [7:0]  serial_a_fifo_ctl_data, serial_b_fifo_ctl_data;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, data_rate_select, rs;
    logic [2:0]  write_select_a;
    logic [6:0]  fl;
    logic [15:0] other_irq_frame_level, irq_frame_force_bit;
    logic [15:0] serirq_frame_level, seed, frc;
    int          n_errors, n_tests, k;
    logic [7:0]  ra [5] = '{8'h60, 8'h6C, 8'h70, 8'h78, 8'h7C};
    logic [7:0]  re [5] = '{8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00};

    runtime_misc_register_bank DUT (.aclk, .aresetn, .hard_reset_n,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .head_step_pulse_n, .drive_select0_n,
        .disk_change_in_n, .disk_change_status, .data_rate_select,
        .write_select_a, .floppy_power_down, .floppy_soft_reset,
        .serial_a_fifo_ctl_wr, .serial_a_fifo_ctl_data,
        .serial_b_fifo_ctl_wr, .serial_b_fifo_ctl_data,
        .irq_generate_enable, .other_irq_frame_level,
        .irq_frame_force_bit, .serirq_frame_level);

    always #25 aclk = ~aclk;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    function automatic logic [31:0] fl_exp(input logic [6:0] f);
        return {24'h0, f[0], f[1], 1'b0, f[4:2], f[6:5]};
    endfunction : fl_exp

    task automatic finish_test;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask : chk

    task automatic hang;
        n_errors++;
        $display("wrong value at %0t: bus hung", $time);
        finish_test();
    endtask : hang

    // upper lanes carry ones so a leak into the register shows up
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int i;
        logic ta, tw;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, 24'hFFFFFF, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (i = 0; i < 40; i++) begin
            @(negedge aclk);
            if (s_axi_bvalid === 1'b1) break;
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        if (i == 40) hang();
        rs = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int i;
        logic ta;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        for (i = 0; i < 40; i++) begin
            @(negedge aclk);
            if (s_axi_rvalid === 1'b1) break;
            ta = s_axi_arvalid & s_axi_arready;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        if (i == 40) hang();
        {rv, rs} = {s_axi_rdata, s_axi_rresp};
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd

    initial begin
        {aclk, aresetn, n_errors, n_tests, seed} = {2'b00, 64'h0, 16'h2DA0};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, s_axi_wstrb, irq_generate_enable} = {36'hF, 1'b0};
        {hard_reset_n, head_step_pulse_n, drive_select0_n} = 3'b111;
        {disk_change_in_n, data_rate_select, write_select_a} = 6'h20;
        {floppy_power_down, floppy_soft_reset, serial_a_fifo_ctl_wr} = '0;
        {serial_b_fifo_ctl_wr, serial_a_fifo_ctl_data} = '0;
        {serial_b_fifo_ctl_data, other_irq_frame_level} = 24'hFFFF;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (k = 0; k < 5; k++) begin
            rd(ra[k]);
            chk(rv, re[k]);
        end
        wr(8'h60, 8'hFE);
        rd(8'h60);
        chk(rv, 32'h1);
        {head_step_pulse_n, drive_select0_n, disk_change_in_n} <= 3'b000;
        @(posedge aclk);
        {head_step_pulse_n, drive_select0_n, disk_change_in_n} <= 3'b110;
        repeat (2) @(negedge aclk);
        chk(disk_change_status, 32'h0);
        rd(8'h60);
        chk(rv, 32'h0);
        wr(8'h60, 8'h01);
        repeat (2) @(negedge aclk);
        chk(disk_change_status, 32'h1);
        irq_generate_enable <= 1'b1;
        for (k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            {fl, ga, gb} = {seed[6:0], seed[15:8], seed[7:0] ^ 8'h5A};
            @(posedge aclk);
            {data_rate_select, write_select_a} <= fl[6:2];
            {floppy_power_down, floppy_soft_reset} <= fl[1:0];
            {serial_a_fifo_ctl_data, serial_b_fifo_ctl_data} <= {ga, gb};
            {serial_a_fifo_ctl_wr, serial_b_fifo_ctl_wr} <= 2'b11;
            @(posedge aclk);
            {serial_a_fifo_ctl_wr, serial_b_fifo_ctl_wr} <= 2'b00;
            seed = lfsr(lfsr(seed));
            {gl, gh} = (k == 0) ? 16'h0000 : seed;
            other_irq_frame_level <= lfsr(seed);
            wr(8'h6C, gl);
            wr(8'h70, gh);
            rd(8'h64);
            chk(rv, fl_exp(fl));
            rd(8'h68);
            chk(rv, {24'h0, ga & FCR_LIVE_MASK});
            rd(8'h74);
            chk(rv, {24'h0, gb & FCR_LIVE_MASK});
            rd(8'h6C);
            chk(rv, {24'h0, gl});
            rd(8'h70);
            chk(rv, {24'h0, gh});
            frc = ~{gh, gl[7:1], 1'b1};
            chk(irq_frame_force_bit, frc);
            chk(serirq_frame_level, other_irq_frame_level & ~frc);
        end
        wr(8'h78, 8'h5A);
        chk(rs, RESP_OKAY);
        rd(8'h78);
        chk(rv, 32'h0);
        rd(8'h80);
        chk(rs, RESP_SLVERR);
        {head_step_pulse_n, drive_select0_n} <= 2'b00;
        irq_generate_enable <= 1'b0;
        repeat (2) @(negedge aclk);
        chk(irq_frame_force_bit, 32'h0);
        rd(8'h6C);
        chk(rv, {24'h0, gl});
        hard_reset_n <= 1'b0;
        @(posedge aclk);
        hard_reset_n <= 1'b1;
        rd(8'h6C);
        chk(rv, 32'hFF);
        rd(8'h70);
        chk(rv, 32'hFF);
        finish_test();
    end
endmodule : tb_top
